// [sim/serial_link_port_reset_test.sv]
// Purpose: self-checking run of both link ends facing each other
// Assumes: rate changes only while both lines are idle
// Notes: the peer reads late so the switch end must wait for acks
`timescale 1ns/1ps
`default_nettype none
`include "sl_params.svh"
module serial_link_port_reset_test;
    logic clk_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic reset_pin = 1'h1;
    logic rate = 1'h0;
    logic [7:0] d_tx_b = 8'h0, p_tx_b = 8'h0, d_rx_b, p_rx_b;
    logic d_tx_v = 1'h0, p_tx_v = 1'h0, d_take = 1'h0, p_take = 1'h0;
    logic d_rdy, p_rdy, d_rx_v, p_rx_v, in_rst;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    sl_link_if i_sl_link_if ();
    sl_dev_end i_sl_dev_end (.clk_in, .rst_b_in, .reset_pin_in(reset_pin),
        .rate_select_in(rate), .link(i_sl_link_if.dev), .setup_tx_byte_in(d_tx_b),
        .setup_tx_valid_in(d_tx_v), .setup_tx_ready_out(d_rdy), .setup_rx_byte_out(d_rx_b),
        .setup_rx_valid_out(d_rx_v), .setup_rx_take_in(d_take), .in_reset_out(in_rst));
    sl_peer_end i_sl_peer_end (.clk_in, .rst_b_in, .rate_select_in(rate),
        .link(i_sl_link_if.peer), .tx_byte_in(p_tx_b), .tx_valid_in(p_tx_v),
        .tx_ready_out(p_rdy), .rx_byte_out(p_rx_b), .rx_valid_out(p_rx_v), .rx_take_in(p_take));
    sl_link_monitor i_sl_link_monitor (.clk_in, .rst_b_in, .rate_select_in(rate),
        .setup_port_tx(i_sl_link_if.setup_port_tx), .setup_port_rx(i_sl_link_if.setup_port_rx),
        .serial_tx_lines(i_sl_link_if.serial_tx_lines));
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("tests_run %0d err_count %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(negedge clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Samples the switch end's setup_port_tx at bit centres from its start edge
    task automatic frame(input logic [7:0] b);
        logic [10:0] w;
        int bc;
        bc = rate ? `SL_BIT_CYC_HIGH : `SL_BIT_CYC_LOW;
        while (i_sl_link_if.setup_port_tx !== 1'h1) @(negedge clk_in);
        repeat (bc / 2) @(negedge clk_in);
        for (int i = 0; i < 11; i++) begin
            w[i] = i_sl_link_if.setup_port_tx;
            repeat (bc) @(negedge clk_in);
        end
        check(32'(w), 32'({1'h0, b, 2'h3}));
    endtask
    task automatic dwr(input logic [7:0] b);
        d_tx_b = b;
        d_tx_v = 1'h1;
        while (d_rdy !== 1'h1) @(negedge clk_in);
        @(negedge clk_in);
        d_tx_v = 1'h0;
        @(negedge clk_in);
    endtask
    task automatic pwr(input logic [7:0] b);
        p_tx_b = b;
        p_tx_v = 1'h1;
        while (p_rdy !== 1'h1) @(negedge clk_in);
        @(negedge clk_in);
        p_tx_v = 1'h0;
        @(negedge clk_in);
    endtask
    task automatic prd(input logic [7:0] exp, input int late);
        while (p_rx_v !== 1'h1) @(negedge clk_in);
        repeat (late) @(negedge clk_in);
        check(32'(p_rx_b), 32'(exp));
        p_take = 1'h1;
        @(negedge clk_in);
        p_take = 1'h0;
        @(negedge clk_in);
    endtask
    task automatic drd(input logic [7:0] exp);
        while (d_rx_v !== 1'h1) @(negedge clk_in);
        check(32'(d_rx_b), 32'(exp));
        d_take = 1'h1;
        @(negedge clk_in);
        d_take = 1'h0;
        @(negedge clk_in);
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(negedge clk_in);
        check(32'(in_rst), 32'h1);
        check(i_sl_link_if.serial_tx_lines, 32'h0);
        rst_b_in = 1'h1;
        repeat (`SL_RESET_HIGH_MIN_CYC) @(negedge clk_in);
        check(32'({in_rst, d_rdy, i_sl_link_if.setup_port_tx}), 32'h4);
        // Limitation: the 10 ms power-on waits are shortened to keep the run short
        reset_pin = 1'h0;
        repeat (8) @(negedge clk_in);
        check(32'({in_rst, d_rdy}), 32'h1);
        for (int r = 0; r < 2; r++) begin
            rate = r[0];
            // The switch end filters the rate pin; traffic waits until it has settled
            repeat (8) @(negedge clk_in);
            fork
                frame(8'hA5);
                begin
                    dwr(8'hA5);
                    dwr(8'h01);
                    dwr(8'h80);
                    dwr(8'hFF);
                end
                begin
                    prd(8'hA5, 300);
                    prd(8'h01, 0);
                    prd(8'h80, 0);
                    prd(8'hFF, 0);
                end
                begin
                    pwr(8'h5A);
                    pwr(8'h00);
                    pwr(8'hC3);
                end
                begin
                    drd(8'h5A);
                    drd(8'h00);
                    drd(8'hC3);
                end
            join
            repeat (100) @(negedge clk_in);
            check(32'({i_sl_link_if.setup_port_tx, i_sl_link_if.setup_port_rx}), 32'h0);
            check(i_sl_link_if.serial_tx_lines, 32'h0);
        end
        end_sim();
    end
endmodule
`default_nettype wire

// [sim/sl_link_monitor.sv]
// Purpose: frame checks on the setup link wires
// Assumes: lines rest low between frames
// Notes: a decoder follows each line from its start edge
`timescale 1ns/1ps
`default_nettype none
`include "sl_params.svh"
module sl_frame_decode (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic line_in,
    input wire logic [7:0] bc_in,
    output logic busy_out,
    output logic flag_out,
    output logic [7:0] cnt_out
);
    logic [7:0] last_w;
    assign last_w = (flag_out ? 8'hB : 8'h2) * bc_in - 8'h1;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            busy_out <= 1'h0;
            flag_out <= 1'h0;
            cnt_out <= 8'h0;
        end else begin
            busy_out <= busy_out ? (cnt_out != last_w) : line_in;
            cnt_out <= busy_out ? cnt_out + 8'h1 : 8'h1;
            flag_out <= (busy_out && cnt_out == bc_in) ? line_in : flag_out;
        end
    end
endmodule

module sl_link_monitor (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic rate_select_in,
    input wire logic setup_port_tx,
    input wire logic setup_port_rx,
    input wire logic [`SL_N_LINKS-1:0] serial_tx_lines
);
    logic [7:0] bc_w;
    logic tb, tf, rb, rf;
    logic [7:0] tc, rc;
    logic [1:0] pend_q, owe_q;
    logic t_dat_w, t_ack_w, r_dat_w, r_ack_w;
    assign bc_w = rate_select_in ? 8'(`SL_BIT_CYC_HIGH) : 8'(`SL_BIT_CYC_LOW);
    // Frame kind is known once the second bit starts
    assign t_dat_w = tb && tc == bc_w && setup_port_tx;
    assign t_ack_w = tb && tc == bc_w && !setup_port_tx;
    assign r_dat_w = rb && rc == bc_w && setup_port_rx;
    assign r_ack_w = rb && rc == bc_w && !setup_port_rx;
    sl_frame_decode i_tx_dec (.clk_in, .rst_b_in, .line_in(setup_port_tx), .bc_in(bc_w),
        .busy_out(tb), .flag_out(tf), .cnt_out(tc));
    sl_frame_decode i_rx_dec (.clk_in, .rst_b_in, .line_in(setup_port_rx), .bc_in(bc_w),
        .busy_out(rb), .flag_out(rf), .cnt_out(rc));
    // Bytes sent by the switch end awaiting an ack, and acks it owes
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pend_q <= 2'h0;
            owe_q <= 2'h0;
        end else begin
            pend_q <= pend_q + {1'h0, t_dat_w} - {1'h0, r_ack_w};
            owe_q <= owe_q + {1'h0, r_dat_w} - {1'h0, t_ack_w};
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence s_peer_data;
        r_dat_w;
    endsequence
    sequence s_dev_ack;
        t_ack_w;
    endsequence
    property p_sw_low;
        serial_tx_lines == '0;
    endproperty
    a_sw_low: assert property (p_sw_low)
        else $error("switch output not low");
    property p_rst_idle;
        $rose(rst_b_in) |-> !setup_port_tx && !setup_port_rx;
    endproperty
    a_rst_idle: assert property (p_rst_idle)
        else $error("line not idle after reset");
    property p_start;
        tb && tc < bc_w |-> setup_port_tx;
    endproperty
    a_start: assert property (p_start)
        else $error("start bit too short");
    property p_hold;
        tb && tc > bc_w && tc % bc_w != 8'h0 |-> $stable(setup_port_tx);
    endproperty
    a_hold: assert property (p_hold)
        else $error("bit changed inside its bit time");
    property p_stop;
        tb && tf && tc >= 8'hA * bc_w |-> !setup_port_tx;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop bit not low");
    property p_ack_low;
        tb && !tf && tc > bc_w |-> !setup_port_tx;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("ack second bit not low");
    property p_dev_wait;
        t_dat_w |-> pend_q == 2'h0;
    endproperty
    a_dev_wait: assert property (p_dev_wait)
        else $error("byte sent before ack");
    property p_ack_owed;
        t_ack_w |-> owe_q != 2'h0;
    endproperty
    a_ack_owed: assert property (p_ack_owed)
        else $error("ack without byte");
    property p_ack_due;
        s_peer_data |-> ##[1:500] s_dev_ack;
    endproperty
    a_ack_due: assert property (p_ack_due)
        else $error("ack missing");
endmodule
`default_nettype wire

// [verilog/sl_dev_end.sv]
// Purpose: switch end of the setup link, with reset and rate services
// Assumes: clk_in is the 200 MHz clock derived from the 5 MHz reference
// Notes: crossbar and setup message decoding live elsewhere
`timescale 1ns/1ps
`default_nettype none
`include "sl_params.svh"
module sl_dev_end
    import sl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic reset_pin_in,
    input wire logic rate_select_in,
    sl_link_if.dev link,
    input wire logic [7:0] setup_tx_byte_in,
    input wire logic setup_tx_valid_in,
    output logic setup_tx_ready_out,
    output logic [7:0] setup_rx_byte_out,
    output logic setup_rx_valid_out,
    input wire logic setup_rx_take_in,
    output logic in_reset_out
);
    logic [1:0] pin_raw;
    logic [1:0] pin_filt_q;
    logic in_reset;
    sl_bitcyc_t bit_cyc;
    sl_tx_state_e tx_state_q;
    logic [10:0] shift_q;
    logic [3:0] left_q;
    sl_bitcyc_t cnt_q;
    logic line_q;
    logic owed_q;
    logic wait_ack_q;
    logic rx_full_q;
    logic pend_q;
    logic [7:0] rx_byte_q;
    logic txh_full_q;
    logic [7:0] txh_byte_q;
    logic tx_ready_q;
    logic in_reset_q;
    logic [`SL_N_LINKS-1:0] sw_out_q;
    logic rx_dstart;
    logic rx_ack;
    logic rx_land;
    logic [7:0] rx_front_byte;
    logic tx_idle;
    logic tick;
    logic ack_go;
    logic data_go;
    logic take;
    logic load_hold;
    logic accept;
    logic [10:0] frame;
    logic [3:0] frame_len;

    // --------------------------------------------------------------
    // Pin inputs
    // --------------------------------------------------------------
    // Bit 0 is the reset pin, bit 1 the rate select pin
    assign pin_raw = {rate_select_in, reset_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            logic [2:0] chain_q;
            always_ff @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    chain_q <= (gi == 0) ? 3'h7 : 3'h0;
                    pin_filt_q[gi] <= (gi == 0) ? 1'h1 : 1'h0;
                end else begin
                    chain_q <= {chain_q[1:0], pin_raw[gi]};
                    if (chain_q[1] == chain_q[2]) begin
                        pin_filt_q[gi] <= chain_q[2];
                    end
                end
            end
        end
    endgenerate

    // Held in reset until the pin is seen low; short pins may be missed
    assign in_reset = pin_filt_q[0];
    // Rate changes take effect at the next bit boundary, so switch it only when idle
    assign bit_cyc = pin_filt_q[1] ? sl_bitcyc_t'(`SL_BIT_CYC_HIGH)
                                   : sl_bitcyc_t'(`SL_BIT_CYC_LOW);

    // --------------------------------------------------------------
    // Receive side
    // --------------------------------------------------------------
    sl_rx_front u_rx (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .clr_in(in_reset),
        .line_in(link.setup_port_rx),
        .bit_cyc_in(bit_cyc),
        .data_start_out(rx_dstart),
        .ack_out(rx_ack),
        .byte_valid_out(rx_land),
        .byte_out(rx_front_byte)
    );

    // --------------------------------------------------------------
    // Decisions
    // --------------------------------------------------------------
    assign tx_idle = (tx_state_q == SL_TX_IDLE) && !in_reset;
    assign tick = (cnt_q == 5'h00);
    // A byte in the front end and one in the hold: ack only with both free
    assign ack_go = tx_idle && owed_q && !rx_full_q && !pend_q;
    assign data_go = tx_idle && !ack_go && txh_full_q && !wait_ack_q;
    assign take = setup_rx_take_in && rx_full_q;
    assign load_hold = (rx_land || pend_q) && (!rx_full_q || take);
    assign accept = setup_tx_valid_in && tx_ready_q;
    assign frame = ack_go ? 11'h001 : {1'h0, txh_byte_q, 2'h3};
    assign frame_len = ack_go ? 4'(`SL_ACK_FRAME_LEN) : 4'(`SL_DATA_FRAME_LEN);

    // --------------------------------------------------------------
    // Transmit shifter
    // --------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_state_q <= SL_TX_IDLE;
            shift_q <= 11'h000;
            left_q <= 4'h0;
            cnt_q <= 5'h00;
            line_q <= `SL_LINE_IDLE;
        end else if (in_reset) begin
            tx_state_q <= SL_TX_IDLE;
            line_q <= `SL_LINE_IDLE;
        end else begin
            cnt_q <= tick ? 5'(bit_cyc - 5'h01) : 5'(cnt_q - 5'h01);
            case (tx_state_q)
                SL_TX_IDLE: begin
                    if (ack_go || data_go) begin
                        tx_state_q <= SL_TX_SEND;
                        line_q <= frame[0];
                        shift_q <= frame >> 1;
                        left_q <= 4'(frame_len - 4'h1);
                        cnt_q <= 5'(bit_cyc - 5'h01);
                    end
                end
                SL_TX_SEND: begin
                    if (tick && left_q == 4'h0) begin
                        tx_state_q <= SL_TX_IDLE;
                        line_q <= `SL_LINE_IDLE;
                    end else if (tick) begin
                        line_q <= shift_q[0];
                        shift_q <= shift_q >> 1;
                        left_q <= 4'(left_q - 4'h1);
                    end
                end
                default: begin
                    tx_state_q <= SL_TX_IDLE;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Flow control and holding registers
    // --------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            owed_q <= 1'h0;
            wait_ack_q <= 1'h0;
            rx_full_q <= 1'h0;
            pend_q <= 1'h0;
            rx_byte_q <= 8'h00;
            txh_full_q <= 1'h0;
            txh_byte_q <= 8'h00;
            tx_ready_q <= 1'h0;
            in_reset_q <= 1'h1;
            sw_out_q <= {`SL_N_LINKS{1'h0}};
        end else begin
            in_reset_q <= in_reset;
            // No crossbar here, so every switch output stays parked low
            sw_out_q <= {`SL_N_LINKS{1'h0}};
            if (in_reset) begin
                owed_q <= 1'h0;
                wait_ack_q <= 1'h0;
                rx_full_q <= 1'h0;
                pend_q <= 1'h0;
                txh_full_q <= 1'h0;
                tx_ready_q <= 1'h0;
            end else begin
                owed_q <= rx_dstart || (owed_q && !ack_go);
                wait_ack_q <= data_go || (wait_ack_q && !rx_ack);
                rx_full_q <= load_hold || (rx_full_q && !take);
                pend_q <= (rx_land || pend_q) && !load_hold;
                if (load_hold) begin
                    rx_byte_q <= rx_front_byte;
                end
                txh_full_q <= accept || (txh_full_q && !data_go);
                if (accept) begin
                    txh_byte_q <= setup_tx_byte_in;
                end
                tx_ready_q <= !(accept || (txh_full_q && !data_go));
            end
        end
    end

    assign link.setup_port_tx = line_q;
    assign link.serial_tx_lines = sw_out_q;
    assign setup_tx_ready_out = tx_ready_q;
    assign setup_rx_byte_out = rx_byte_q;
    assign setup_rx_valid_out = rx_full_q;
    assign in_reset_out = in_reset_q;
endmodule
`default_nettype wire

// [verilog/sl_link_if.sv]
// Purpose: wires between the switch end and its peer
// Assumes: both ends on one clock in simulation; lines still treated as async
// Notes: switch outputs only observed by the bench
`timescale 1ns/1ps
`default_nettype none
`include "sl_params.svh"
interface sl_link_if;
    logic setup_port_tx;
    logic setup_port_rx;
    logic [`SL_N_LINKS-1:0] serial_tx_lines;
    modport dev (
        output setup_port_tx,
        output serial_tx_lines,
        input setup_port_rx
    );
    modport peer (
        input setup_port_tx,
        output setup_port_rx
    );
endinterface
`default_nettype wire

// [verilog/sl_params.svh]
// Purpose: shared constants of the serial link ends
// Assumes: core clock of 200 MHz
// Notes: times keep their own unit, cycle counts derive from them
`ifndef SL_PARAMS_SVH
`define SL_PARAMS_SVH
`define SL_CLK_PERIOD_NS 5
`define SL_REF_CLOCK_PERIOD_NS 200
`define SL_CLK_PER_REF (`SL_REF_CLOCK_PERIOD_NS / `SL_CLK_PERIOD_NS)
`define SL_BIT_NS_LOW_RATE 100
`define SL_BIT_NS_HIGH_RATE 50
`define SL_BIT_CYC_LOW (`SL_BIT_NS_LOW_RATE / `SL_CLK_PERIOD_NS)
`define SL_BIT_CYC_HIGH (`SL_BIT_NS_HIGH_RATE / `SL_CLK_PERIOD_NS)
`define SL_RESET_HIGH_MIN_WIDTH 8
`define SL_RESET_HIGH_MIN_CYC (`SL_RESET_HIGH_MIN_WIDTH * `SL_CLK_PER_REF)
`define SL_CLOCK_BEFORE_RESET_RELEASE_MS 10
`define SL_POWER_BEFORE_RESET_RELEASE_MS 10
`define SL_N_LINKS 32
`define SL_DATA_FRAME_LEN 11
`define SL_ACK_FRAME_LEN 2
`define SL_DATA_LAST_BIT 7
`define SL_LINE_IDLE 1'h0
`endif

// [verilog/sl_peer_end.sv]
// Purpose: peer end that talks to the switch setup link
// Assumes: rate_select_in comes from logic on clk_in
// Notes: acknowledges only after the user has taken the byte
`timescale 1ns/1ps
`default_nettype none
`include "sl_params.svh"
module sl_peer_end
    import sl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic rate_select_in,
    sl_link_if.peer link,
    input wire logic [7:0] tx_byte_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic [7:0] rx_byte_out,
    output logic rx_valid_out,
    input wire logic rx_take_in
);
    sl_bitcyc_t bit_cyc;
    sl_tx_state_e tx_state_q;
    logic [10:0] shift_q;
    logic [3:0] left_q;
    sl_bitcyc_t cnt_q;
    logic line_q;
    logic owed_q;
    logic wait_ack_q;
    logic rx_full_q;
    logic [7:0] rx_byte_q;
    logic txh_full_q;
    logic [7:0] txh_byte_q;
    logic tx_ready_q;
    logic rx_ack;
    logic rx_land;
    logic [7:0] rx_front_byte;
    logic tick;
    logic ack_go;
    logic data_go;
    logic accept;
    logic [10:0] frame;
    logic [3:0] frame_len;

    assign bit_cyc = rate_select_in ? sl_bitcyc_t'(`SL_BIT_CYC_HIGH)
                                    : sl_bitcyc_t'(`SL_BIT_CYC_LOW);

    sl_rx_front u_rx (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .clr_in(1'h0),
        .line_in(link.setup_port_tx),
        .bit_cyc_in(bit_cyc),
        .data_start_out(),
        .ack_out(rx_ack),
        .byte_valid_out(rx_land),
        .byte_out(rx_front_byte)
    );

    // --------------------------------------------------------------
    // Decisions
    // --------------------------------------------------------------
    assign tick = (cnt_q == 5'h00);
    // Simpler than overlapping: the ack waits for an empty hold
    assign ack_go = (tx_state_q == SL_TX_IDLE) && owed_q && !rx_full_q;
    assign data_go = (tx_state_q == SL_TX_IDLE) && !ack_go && txh_full_q && !wait_ack_q;
    assign accept = tx_valid_in && tx_ready_q;
    assign frame = ack_go ? 11'h001 : {1'h0, txh_byte_q, 2'h3};
    assign frame_len = ack_go ? 4'(`SL_ACK_FRAME_LEN) : 4'(`SL_DATA_FRAME_LEN);

    // --------------------------------------------------------------
    // Transmit shifter
    // --------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_state_q <= SL_TX_IDLE;
            shift_q <= 11'h000;
            left_q <= 4'h0;
            cnt_q <= 5'h00;
            line_q <= `SL_LINE_IDLE;
        end else begin
            cnt_q <= tick ? 5'(bit_cyc - 5'h01) : 5'(cnt_q - 5'h01);
            case (tx_state_q)
                SL_TX_IDLE: begin
                    if (ack_go || data_go) begin
                        tx_state_q <= SL_TX_SEND;
                        line_q <= frame[0];
                        shift_q <= frame >> 1;
                        left_q <= 4'(frame_len - 4'h1);
                        cnt_q <= 5'(bit_cyc - 5'h01);
                    end
                end
                SL_TX_SEND: begin
                    if (tick && left_q == 4'h0) begin
                        tx_state_q <= SL_TX_IDLE;
                        line_q <= `SL_LINE_IDLE;
                    end else if (tick) begin
                        line_q <= shift_q[0];
                        shift_q <= shift_q >> 1;
                        left_q <= 4'(left_q - 4'h1);
                    end
                end
                default: begin
                    tx_state_q <= SL_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            owed_q <= 1'h0;
            wait_ack_q <= 1'h0;
            rx_full_q <= 1'h0;
            rx_byte_q <= 8'h00;
            txh_full_q <= 1'h0;
            txh_byte_q <= 8'h00;
            tx_ready_q <= 1'h0;
        end else begin
            owed_q <= rx_land || (owed_q && !ack_go);
            wait_ack_q <= data_go || (wait_ack_q && !rx_ack);
            rx_full_q <= rx_land || (rx_full_q && !rx_take_in);
            if (rx_land) begin
                rx_byte_q <= rx_front_byte;
            end
            txh_full_q <= accept || (txh_full_q && !data_go);
            if (accept) begin
                txh_byte_q <= tx_byte_in;
            end
            tx_ready_q <= !(accept || (txh_full_q && !data_go));
        end
    end

    assign link.setup_port_rx = line_q;
    assign tx_ready_out = tx_ready_q;
    assign rx_byte_out = rx_byte_q;
    assign rx_valid_out = rx_full_q;
endmodule
`default_nettype wire

// [verilog/sl_pkg.sv]
// Purpose: types shared by both link ends
// Assumes: nothing
// Notes: state codes are one-hot
`default_nettype none
package sl_pkg;
    typedef logic [4:0] sl_bitcyc_t;
    typedef enum logic [3:0] {
        SL_RX_IDLE = 4'h1,
        SL_RX_FLAG = 4'h2,
        SL_RX_DATA = 4'h4,
        SL_RX_STOP = 4'h8
    } sl_rx_state_e;
    typedef enum logic [1:0] {
        SL_TX_IDLE = 2'h1,
        SL_TX_SEND = 2'h2
    } sl_tx_state_e;
endpackage
`default_nettype wire

// [verilog/sl_rx_front.sv]
// Purpose: receive side of one link line
// Assumes: line is asynchronous to clk_in
// Notes: pulses last one cycle; byte_out holds until next data byte
`timescale 1ns/1ps
`default_nettype none
`include "sl_params.svh"
module sl_rx_front
    import sl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic clr_in,
    input wire logic line_in,
    input wire sl_bitcyc_t bit_cyc_in,
    output logic data_start_out,
    output logic ack_out,
    output logic byte_valid_out,
    output logic [7:0] byte_out
);
    logic [2:0] sync_q;
    logic stable_q;
    sl_rx_state_e state_q;
    sl_bitcyc_t cnt_q;
    logic [2:0] bits_q;
    logic agree;
    logic rise;
    logic tick;
    sl_bitcyc_t first_wait;

    // --------------------------------------------------------------
    // Resynchroniser
    // --------------------------------------------------------------
    assign agree = (sync_q[1] == sync_q[2]);
    assign rise = agree && sync_q[2] && !stable_q;
    assign tick = (cnt_q == 5'h00);
    // One and a half bits lands in the middle of the flag bit
    assign first_wait = 5'(bit_cyc_in + (bit_cyc_in >> 1) - 5'h01);

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync_q <= 3'h0;
            stable_q <= 1'h0;
        end else begin
            sync_q <= {sync_q[1:0], line_in};
            if (agree) begin
                stable_q <= sync_q[2];
            end
        end
    end

    // --------------------------------------------------------------
    // Packet decoder
    // --------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_q <= SL_RX_IDLE;
            cnt_q <= 5'h00;
            bits_q <= 3'h0;
            byte_out <= 8'h00;
            data_start_out <= 1'h0;
            ack_out <= 1'h0;
            byte_valid_out <= 1'h0;
        end else begin
            data_start_out <= 1'h0;
            ack_out <= 1'h0;
            byte_valid_out <= 1'h0;
            cnt_q <= tick ? 5'(bit_cyc_in - 5'h01) : 5'(cnt_q - 5'h01);
            if (clr_in) begin
                state_q <= SL_RX_IDLE;
            end else begin
                case (state_q)
                    SL_RX_IDLE: begin
                        if (rise) begin
                            state_q <= SL_RX_FLAG;
                            cnt_q <= first_wait;
                        end
                    end
                    SL_RX_FLAG: begin
                        if (tick && stable_q) begin
                            state_q <= SL_RX_DATA;
                            bits_q <= 3'h0;
                            data_start_out <= 1'h1;
                        end else if (tick) begin
                            state_q <= SL_RX_IDLE;
                            ack_out <= 1'h1;
                        end
                    end
                    SL_RX_DATA: begin
                        if (tick) begin
                            byte_out <= {stable_q, byte_out[7:1]};
                            bits_q <= 3'(bits_q + 3'h1);
                            if (bits_q == 3'(`SL_DATA_LAST_BIT)) begin
                                state_q <= SL_RX_STOP;
                            end
                        end
                    end
                    SL_RX_STOP: begin
                        // A high stop bit is not flagged; the next start waits for a low
                        if (tick) begin
                            state_q <= SL_RX_IDLE;
                            byte_valid_out <= 1'h1;
                        end
                    end
                    default: begin
                        state_q <= SL_RX_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire
